// ### rtl/scmc_cfg.svh
// Purpose: Constants for the system clock and mode control block.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes: Offsets, field positions, reset values and timing counts.
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCMC_OFF_MODE 4'h0
`define SCMC_OFF_AUX 4'h4
`define SCMC_OFF_CTRL 4'h8
`define SCMC_OFF_STAT 4'hc

// ****************************************************************
// Field positions
// ****************************************************************
`define SCMC_BIT_FAST 0
`define SCMC_BIT_IDLE 1
`define SCMC_BIT_HRDY 2
`define SCMC_BIT_LRDY 3
`define SCMC_BIT_SEL_LO 5
`define SCMC_BIT_KEEP 7
`define SCMC_BIT_HALT 0
`define SCMC_BIT_WAKE 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SCMC_MODE_RST 3'h0
`define SCMC_IDLE_RST 1'h1
`define SCMC_FAST_RST 1'h1
`define SCMC_KEEP_RST 1'h0

// ****************************************************************
// Oscillator settle counts in clock cycles
// ****************************************************************
`define SCMC_LRDY_CYC 5'h01
`define SCMC_HRDY_CYC 5'h0f

`endif

// ### rtl/scmc_pkg.sv
// Purpose: Types for the system clock and mode control block.
// Assumes: Included constants header supplies numeric values.
// Notes: Types only; numbers live in the header.
package scmc_pkg;

    // Operating modes of the device.
    typedef enum logic [2:0] {
        SCMC_FAST,
        SCMC_SLOW,
        SCMC_IDLE_OFF,
        SCMC_IDLE_ON,
        SCMC_SLEEP
    } scmc_mode_t;

    // Clock source for the system clock.
    typedef enum logic [2:0] {
        SCMC_SRC_FH,
        SCMC_SRC_SL,
        SCMC_SRC_DIV2,
        SCMC_SRC_DIV4,
        SCMC_SRC_DIV8,
        SCMC_SRC_DIV16,
        SCMC_SRC_DIV32,
        SCMC_SRC_DIV64
    } scmc_src_t;

    // Clock and power status bundle sent to the clock tree.
    typedef struct packed {
        scmc_src_t src;
        logic sys_clk_en;
        logic cpu_clk_en;
        logic fast_osc_en;
        logic low_ready;
        logic high_ready;
    } scmc_status_t;

endpackage : scmc_pkg

// ### rtl/scmc_ready.sv
// Purpose: Oscillator ready flag with a settle counter.
// Assumes: osc_run_i is synchronous to clk_i.
// Notes: Flag rises CYCLES+1 edges after the oscillator starts running.
`timescale 1ns/100ps
`default_nettype none
module scmc_ready #(
    parameter int W = 5,
    parameter logic [W-1:0] CYCLES = 5'h01
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_run_i,
    output logic ready_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic ready;
    } scmc_rdy_state_t;

    scmc_rdy_state_t state_reg;
    scmc_rdy_state_t state_next;

    // Count settle cycles while running; drop flag whenever stopped.
    always_comb begin
        state_next = state_reg;
        if (!osc_run_i) begin
            state_next.cnt = '0;
            state_next.ready = 1'b0;
        end else if (!state_reg.ready) begin
            if (state_reg.cnt == CYCLES) begin
                state_next.ready = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ready_o = state_reg.ready;

endmodule // scmc_ready
`default_nettype wire

// ### rtl/scmc_top.sv
// Purpose: System clock selection and operating mode control with Wishbone access.
// Assumes: Single clock; halt and wake come from CPU logic on the same clock.
// Notes: Clock enables steer an external clock tree; no clock is gated here.
//
// Summary of operation
// - Select codes 000 and 001 pick slow oscillator.
// - Codes 010, 011, 100 divide by 64, 32, 16.
// - Code 101 divides by 4, 111 by 2.
// - Fast select high uses undivided fast clock.
// - Halt enters idle if idle select, else sleep.
// - Idle with keep bit keeps system clock.
// - Idle without keep bit stops CPU and clock.
// - Read-only slow oscillator ready flag.
// - Slow ready low asleep, rises 1-2 cycles.
// - Fast ready cleared at reset, set when stable.
// - Fast ready low clock-off, rises 15-16 cycles.
// - Bit 4 of mode register reads zero.
// - Idle flavour chosen by the keep bit.
// - Slow oscillator as clock stops fast oscillator.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "scmc_cfg.svh"
module scmc_top
    import scmc_pkg::*;
#(
    parameter int CNT_W = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic halt_i,
    input wire logic wake_i,
    output var scmc_status_t status_o,
    output var scmc_mode_t mode_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0] slow_clock_select;
        logic idle_select;
        logic fast_clock_select;
        logic idle_sysclk_keep;
        scmc_mode_t mode;
        logic ack;
        logic [31:0] rdata;
        scmc_status_t status;
    } scmc_state_t;

    scmc_state_t state_reg;
    scmc_state_t state_next;

    logic low_osc_ready;
    logic high_osc_ready;
    logic low_run;
    logic high_run;
    logic wr_en;
    logic rd_en;
    logic halt_now;
    logic wake_now;
    scmc_src_t src_sel;

    // ****************************************************************
    // Oscillator ready flags
    // ****************************************************************

    // Slow oscillator runs except in deep sleep.
    assign low_run = (state_reg.mode != SCMC_SLEEP);
    // Fast oscillator stops in sleep, clock-off idle and when slow RC clocks the system.
    assign high_run = (state_reg.mode != SCMC_SLEEP)
        && (state_reg.mode != SCMC_IDLE_OFF)
        && !(src_sel == SCMC_SRC_SL);

    scmc_ready #(
        .W(CNT_W),
        .CYCLES(CNT_W'(`SCMC_LRDY_CYC))
    ) u_low_ready (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_run_i(low_run),
        .ready_o(low_osc_ready)
    );

    scmc_ready #(
        .W(CNT_W),
        .CYCLES(CNT_W'(`SCMC_HRDY_CYC))
    ) u_high_ready (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_run_i(high_run),
        .ready_o(high_osc_ready)
    );

    // ****************************************************************
    // Clock source decode
    // ****************************************************************

    // Map the fast select bit and slow select code to a source.
    always_comb begin
        src_sel = SCMC_SRC_FH;
        if (!state_reg.fast_clock_select) begin
            unique case (state_reg.slow_clock_select)
                3'h0: src_sel = SCMC_SRC_SL;
                3'h1: src_sel = SCMC_SRC_SL;
                3'h2: src_sel = SCMC_SRC_DIV64;
                3'h3: src_sel = SCMC_SRC_DIV32;
                3'h4: src_sel = SCMC_SRC_DIV16;
                3'h5: src_sel = SCMC_SRC_DIV4;
                3'h6: src_sel = SCMC_SRC_DIV8;
                3'h7: src_sel = SCMC_SRC_DIV2;
            endcase
        end else begin
            src_sel = SCMC_SRC_FH;
        end
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // Classic cycle: ack follows the request by one cycle and drops the cycle after.
    // A write lands on the edge at which the master samples ack, never earlier.
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack;
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !state_reg.ack;

    // Software halt and wake strobes in the control register.
    assign halt_now = halt_i || (wr_en && wb_adr_i == `SCMC_OFF_CTRL && wb_sel_i[0]
        && wb_dat_i[`SCMC_BIT_HALT]);
    assign wake_now = wake_i || (wr_en && wb_adr_i == `SCMC_OFF_CTRL && wb_sel_i[0]
        && wb_dat_i[`SCMC_BIT_WAKE]);

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Register writes, read mux, mode sequencing and output bundle.
    always_comb begin
        state_next = state_reg;
        state_next.ack = wb_cyc_i && wb_stb_i && !state_reg.ack;

        // Register writes on the low byte lane.
        if (wr_en && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                `SCMC_OFF_MODE: begin
                    state_next.slow_clock_select = wb_dat_i[`SCMC_BIT_SEL_LO +: 3];
                    state_next.idle_select = wb_dat_i[`SCMC_BIT_IDLE];
                    state_next.fast_clock_select = wb_dat_i[`SCMC_BIT_FAST];
                end
                `SCMC_OFF_AUX: begin
                    state_next.idle_sysclk_keep = wb_dat_i[`SCMC_BIT_KEEP];
                end
                default: begin
                end
            endcase
        end

        // Read data; ready bits are read-only and bit 4 reads zero.
        state_next.rdata = '0;
        if (rd_en) begin
            unique case (wb_adr_i)
                `SCMC_OFF_MODE: begin
                    state_next.rdata[`SCMC_BIT_SEL_LO +: 3] = state_reg.slow_clock_select;
                    state_next.rdata[4] = 1'b0;
                    state_next.rdata[`SCMC_BIT_LRDY] = low_osc_ready;
                    state_next.rdata[`SCMC_BIT_HRDY] = high_osc_ready;
                    state_next.rdata[`SCMC_BIT_IDLE] = state_reg.idle_select;
                    state_next.rdata[`SCMC_BIT_FAST] = state_reg.fast_clock_select;
                end
                `SCMC_OFF_AUX: begin
                    state_next.rdata[`SCMC_BIT_KEEP] = state_reg.idle_sysclk_keep;
                end
                `SCMC_OFF_STAT: begin
                    state_next.rdata[2:0] = state_reg.mode;
                end
                default: begin
                end
            endcase
        end

        // Operating mode sequencing; wake wins over a halt in the same cycle.
        unique case (state_reg.mode)
            SCMC_FAST, SCMC_SLOW: begin
                if (halt_now && !wake_now) begin
                    if (state_reg.idle_select) begin
                        if (state_reg.idle_sysclk_keep) begin
                            state_next.mode = SCMC_IDLE_ON;
                        end else begin
                            state_next.mode = SCMC_IDLE_OFF;
                        end
                    end else begin
                        state_next.mode = SCMC_SLEEP;
                    end
                end else begin
                    state_next.mode = (src_sel == SCMC_SRC_FH) ? SCMC_FAST : SCMC_SLOW;
                end
            end
            SCMC_IDLE_OFF, SCMC_IDLE_ON, SCMC_SLEEP: begin
                if (wake_now) begin
                    state_next.mode = (src_sel == SCMC_SRC_FH) ? SCMC_FAST : SCMC_SLOW;
                end
            end
            default: begin
                state_next.mode = SCMC_FAST;
            end
        endcase

        // Clock tree steering follows the registered mode.
        state_next.status.src = src_sel;
        state_next.status.cpu_clk_en = (state_reg.mode == SCMC_FAST)
            || (state_reg.mode == SCMC_SLOW);
        state_next.status.sys_clk_en = state_next.status.cpu_clk_en
            || (state_reg.mode == SCMC_IDLE_ON);
        state_next.status.fast_osc_en = high_run;
        state_next.status.low_ready = low_osc_ready;
        state_next.status.high_ready = high_osc_ready;
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset gives the power-on defaults.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.slow_clock_select <= `SCMC_MODE_RST;
            state_reg.idle_select <= `SCMC_IDLE_RST;
            state_reg.fast_clock_select <= `SCMC_FAST_RST;
            state_reg.idle_sysclk_keep <= `SCMC_KEEP_RST;
            state_reg.mode <= SCMC_FAST;
            state_reg.status.src <= SCMC_SRC_FH;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register.
    assign wb_dat_o = state_reg.rdata;
    assign wb_ack_o = state_reg.ack;
    assign status_o = state_reg.status;
    assign mode_o = state_reg.mode;

endmodule // scmc_top
`default_nettype wire

// ### sim/scmc_props.sv
// Purpose: Port-level assertions for the clock and mode control block.
// Assumes: One clock; rst_i is synchronous and active high.
// Notes: Bound into scmc_top below the module.
`timescale 1ns/100ps
`default_nettype none
module scmc_props
    import scmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire scmc_status_t status_o,
    input wire scmc_mode_t mode_o
);
    // ********
    // Assertions
    // ********
    // All checks share the one clock and its reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A bus request still waiting for its answer.
    sequence s_wait;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    // Fast mode on two edges, so the lagging status has caught up.
    sequence s_fast_held;
        mode_o == SCMC_FAST ##1 mode_o == SCMC_FAST;
    endsequence

    a_ack_one_pulse: assert property (s_wait |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse");
    a_read_bit4_zero: assert property (!wb_dat_o[4] && wb_dat_o[31:8] == 24'h0)
        else $error("bit 4 or upper read bits set");
    a_fast_src_fh: assert property (s_fast_held |-> status_o.src == SCMC_SRC_FH)
        else $error("fast mode not on the undivided clock");
    a_idle_off_stops: assert property (mode_o == SCMC_IDLE_OFF |=>
        !status_o.sys_clk_en && !status_o.cpu_clk_en ##1 !status_o.high_ready)
        else $error("clock-off idle left something on");
    a_idle_on_runs: assert property (mode_o == SCMC_IDLE_ON |=>
        status_o.sys_clk_en && !status_o.cpu_clk_en)
        else $error("clock-on idle has wrong enables");
    a_sleep_all_off: assert property (mode_o == SCMC_SLEEP |=>
        !status_o.sys_clk_en ##1 !status_o.low_ready && !status_o.high_ready)
        else $error("sleep left something on");
    a_slow_osc_stop: assert property (status_o.src == SCMC_SRC_SL |->
        !status_o.fast_osc_en)
        else $error("fast oscillator runs on slow clock");
    a_high_settle: assert property ($rose(status_o.high_ready) |->
        $past(status_o.fast_osc_en, 15))
        else $error("fast ready rose too soon");
endmodule // scmc_props

bind scmc_top scmc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .status_o(status_o),
    .mode_o(mode_o));
`default_nettype wire

// ### sim/tb_system_clock_mode_control.sv
// Purpose: Self-checking bench for the clock and mode control block.
// Assumes: Classic Wishbone master on a 200 MHz clock.
// Notes: Reset, the select-code table, then halt and wake cases.
`timescale 1ns/100ps
`default_nettype none
`include "scmc_cfg.svh"
module tb_system_clock_mode_control
    import scmc_pkg::*;
;
    // ********
    // Bench
    // ********
    typedef struct packed {logic [2:0] code; scmc_src_t src;} scmc_row_t;
    // Each select code beside the clock source it must give.
    scmc_row_t rows [8] = '{'{3'h0, SCMC_SRC_SL}, '{3'h1, SCMC_SRC_SL}, '{3'h2, SCMC_SRC_DIV64},
        '{3'h3, SCMC_SRC_DIV32}, '{3'h4, SCMC_SRC_DIV16}, '{3'h5, SCMC_SRC_DIV4},
        '{3'h6, SCMC_SRC_DIV8}, '{3'h7, SCMC_SRC_DIV2}};
    logic clk_i, rst_i, req, we, halt, wake, ack;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, q;
    scmc_status_t st;
    scmc_mode_t md, em;
    int n_fail = 0;
    int num_checks = 0;
    int n;

    // Block under test; cyc and stb move together.
    scmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .halt_i(halt), .wake_i(wake), .status_o(st), .mode_o(md));

    // Free-running clock.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // One classic bus cycle, held until ack is sampled high.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        chk("bus answer", 32'h1, {31'h0, ack});
        q = rdat;
        req <= 1'b0;
        we <= 1'b0;
    endtask

    // One-cycle halt or wake pulse.
    task automatic pulse(input logic h);
        @(posedge clk_i);
        halt <= h;
        wake <= !h;
        @(posedge clk_i);
        halt <= 1'b0;
        wake <= 1'b0;
    endtask

    // Reset, the table, then halt and wake cases and a second reset.
    initial begin
        {rst_i, req, we, halt, wake, adr, wdat} = {5'h10, 4'h0, 32'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `SCMC_OFF_MODE, 8'h0);
        chk("mode reg", 32'h03, q & 32'hf7);
        repeat (20) @(posedge clk_i);
        bus(1'b0, `SCMC_OFF_MODE, 8'h0);
        chk("ready bits", 32'h0f, q);
        bus(1'b1, `SCMC_OFF_AUX, 8'hff);
        bus(1'b0, `SCMC_OFF_AUX, 8'h0);
        chk("aux reg", 32'h80, q);
        bus(1'b0, 4'h2, 8'h0);
        chk("unmapped", 32'h0, q);
        foreach (rows[i]) begin
            bus(1'b1, `SCMC_OFF_MODE, {rows[i].code, 5'h10});
            repeat (3) @(posedge clk_i);
            chk("source", {29'h0, rows[i].src}, {29'h0, st.src});
            chk("osc", {31'h0, rows[i].src != SCMC_SRC_SL}, {31'h0, st.fast_osc_en});
            bus(1'b0, `SCMC_OFF_MODE, 8'h0);
            chk("select", {24'h0, rows[i].code, 5'h0}, q & 32'hf3);
        end
        // Clock-on idle, clock-off idle by register, then sleep.
        for (int c = 0; c < 3; c++) begin
            em = c == 0 ? SCMC_IDLE_ON : (c == 1 ? SCMC_IDLE_OFF : SCMC_SLEEP);
            bus(1'b1, `SCMC_OFF_AUX, c == 0 ? 8'h80 : 8'h0);
            bus(1'b1, `SCMC_OFF_MODE, c == 2 ? 8'h01 : 8'h03);
            repeat (20) @(posedge clk_i);
            if (c == 1) bus(1'b1, `SCMC_OFF_CTRL, 8'h01);
            else pulse(1'b1);
            pulse(1'b1);
            repeat (2) @(posedge clk_i);
            chk("halt mode", {29'h0, em}, {29'h0, md});
            chk("clk en", {30'h0, c == 0, 1'b0}, {30'h0, st.sys_clk_en, st.cpu_clk_en});
            chk("ready", {30'h0, c != 2, c == 0}, {30'h0, st.low_ready, st.high_ready});
            bus(1'b0, `SCMC_OFF_STAT, 8'h0);
            chk("stat reg", {29'h0, em}, q);
            // The clock-off idle case wakes through the control register.
            if (c == 1) begin
                bus(1'b1, `SCMC_OFF_CTRL, 8'h02);
            end else begin
                pulse(1'b0);
            end
            n = 0;
            while (st.high_ready !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                n++;
            end
            // Settle of 15 or 16 edges, plus the status lag and the sampling edge.
            if (c != 0) chk("ready delay", 32'h1, {31'h0, n >= 17 && n <= 18});
            repeat (3) @(posedge clk_i);
            chk("woken", {28'h0, SCMC_FAST, 1'b1}, {28'h0, md, st.low_ready});
        end
        // Halt and wake in one control write: wake wins and the mode stays fast.
        bus(1'b1, `SCMC_OFF_CTRL, 8'h03);
        repeat (2) @(posedge clk_i);
        chk("wake wins", {29'h0, SCMC_FAST}, {29'h0, md});
        bus(1'b1, `SCMC_OFF_MODE, 8'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `SCMC_OFF_MODE, 8'h0);
        chk("mode reg", 32'h03, q & 32'hf7);
        tally_and_finish();
    end

    // Cuts a hang short after far more time than the tests need.
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
endmodule // tb_system_clock_mode_control
`default_nettype wire
